// ---- bench/serial_nand_instruction_decoder_tb.sv ----
/*
 Self-checking bench for the serial NAND instruction front end.
 Assumes the host model drives the link and the bench plays the array.
*/
`timescale 1ns/100ps
`default_nettype none
module serial_nand_instruction_decoder_tb;
   import serial_nand_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic quad_inhibit = 1'b0;
   logic array_done = 1'b0;
   logic rd_valid = 1'b0;
   logic [7:0] rd_data = 8'h00;
   logic cs_n, sclk, rd_ready, busy, wel, buf_invalid;
   logic [3:0] lane_in, lane_out, lane_oe;
   logic [7:0] cmd_code, b, pgm_data;
   logic cmd_exec, buf_restart, pgm_valid;
   logic [31:0] cmd_arg;
   int n_exec = 0;
   int n_rst = 0;
   int n_inv = 0;
   int miscompares = 0;
   int num_checks = 0;
   // Count one-cycle pulses so that tasks can judge them later
   always @(posedge mclk) begin
      if (cmd_exec) n_exec++;
      if (buf_restart) n_rst++;
      if (buf_invalid) n_inv++;
   end
   always #5 mclk = ~mclk;
   spi_host_model spi_host_model_i (.mclk(mclk), .cs_n(cs_n), .sclk(sclk),
      .lane_in(lane_in), .lane_out(lane_out));
   serial_nand_instruction_decoder serial_nand_instruction_decoder_i (.mclk(mclk),
      .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .lane_in(lane_in), .lane_out(lane_out),
      .lane_oe(lane_oe), .quad_inhibit(quad_inhibit), .array_done(array_done),
      .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .pgm_data(pgm_data),
      .pgm_valid(pgm_valid), .buf_restart(buf_restart), .cmd_exec(cmd_exec),
      .cmd_code(cmd_code), .cmd_arg(cmd_arg),
      .busy(busy), .wel(wel), .buf_invalid(buf_invalid));
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim
   task chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task cmd1(input logic [7:0] op, input int n);
      spi_host_model_i.open_f();
      spi_host_model_i.put(op, n);
      spi_host_model_i.close_f();
   endtask : cmd1
   task t_busy_gate;
      spi_host_model_i.open_f();
      spi_host_model_i.put(OP_PAGE_READ, 32);
      spi_host_model_i.close_f();
      chk({7'h00, busy}, 8'h01);
      chk(cmd_arg[23:16], OP_PAGE_READ);
      cmd1(OP_WREN, 8);
      chk({7'h00, wel}, 8'h00);
      chk(cmd_code, OP_PAGE_READ);
      spi_host_model_i.open_f();
      spi_host_model_i.put(OP_RDSR_A, 8);
      spi_host_model_i.put(8'hC0, 8);
      spi_host_model_i.get1(b);
      spi_host_model_i.close_f();
      chk(b, 8'h01);
      array_done = 1'b1;
      spi_host_model_i.tk(1);
      array_done = 1'b0;
      spi_host_model_i.tk(3);
      chk({7'h00, busy}, 8'h00);
   endtask : t_busy_gate
   task t_wren;
      cmd1(OP_WREN, 8);
      chk(cmd_code, OP_WREN);
      chk({7'h00, wel}, 8'h01);
      cmd1(OP_WRDI, 9);
      chk({7'h00, wel}, 8'h01);
      chk(8'(n_exec), 8'h03);
   endtask : t_wren
   task t_load;
      cmd1(OP_LOAD, 32);
      chk(pgm_data, OP_LOAD);
      chk(8'(n_rst), 8'h01);
   endtask : t_load
   task t_quad_read;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         rd_data = 8'hA5 + 8'(i);
         rd_valid = 1'b1;
         spi_host_model_i.tk(1);
      end
      rd_valid = 1'b0;
      spi_host_model_i.tk(1);
      chk({7'h00, rd_ready}, 8'h00);
      spi_host_model_i.open_f();
      spi_host_model_i.put(OP_X4_OUT, 8);
      spi_host_model_i.put(8'h00, 32);
      spi_host_model_i.get4(b);
      chk(b, 8'hA5);
      spi_host_model_i.get4(b);
      chk(b, 8'hA6);
      spi_host_model_i.put(8'h00, 3);
      spi_host_model_i.close_f();
      chk({7'h00, busy}, 8'h01);
      chk({7'h00, rd_ready}, 8'h01);
      chk(8'(n_inv), 8'h01);
      for (int i = 0; i < 600 && busy !== 1'b0; i++) spi_host_model_i.tk(1);
      chk({7'h00, busy}, 8'h00);
      if (busy !== 1'b0) end_sim();
   endtask : t_quad_read
   task t_inhibit;
      quad_inhibit = 1'b1;
      spi_host_model_i.open_f();
      spi_host_model_i.put(OP_X4_OUT, 40);
      spi_host_model_i.tk(8);
      chk({4'h0, lane_oe}, 8'h00);
      spi_host_model_i.close_f();
      quad_inhibit = 1'b0;
   endtask : t_inhibit
   initial begin
      spi_host_model_i.tk(8);
      rst_n = 1'b1;
      spi_host_model_i.tk(4);
      t_busy_gate();
      t_wren();
      t_load();
      t_quad_read();
      t_inhibit();
      end_sim();
   end
endmodule : serial_nand_instruction_decoder_tb
`default_nettype wire

// ---- bench/spi_host_model.sv ----
/*
 Host side of the serial link: chip select, serial clock and data lanes.
 Assumes the design samples these pins with its own 100 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
   input wire logic mclk,
   output logic cs_n,
   output logic sclk,
   output logic [3:0] lane_in,
   input wire logic [3:0] lane_out
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      lane_in = 4'h0;
   end
   task tk(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tk
   task open_f;
      tk(8);
      cs_n = 1'b0;
      tk(8);
   endtask : open_f
   task put(input logic [7:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         lane_in[0] = b[7 - (i % 8)];
         tk(4);
         sclk = 1'b1;
         tk(4);
         sclk = 1'b0;
      end
   endtask : put
   task get4(output logic [7:0] b);
      for (int i = 1; i >= 0; i--) begin
         tk(4);
         sclk = 1'b1;
         b[i*4+:4] = lane_out;
         tk(4);
         sclk = 1'b0;
      end
   endtask : get4
   task get1(output logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         tk(4);
         sclk = 1'b1;
         b[i] = lane_out[1];
         tk(4);
         sclk = 1'b0;
      end
   endtask : get1
   task close_f;
      tk(8);
      cs_n = 1'b1;
      lane_in = ~lane_in;
      tk(20);
   endtask : close_f
endmodule : spi_host_model
`default_nettype wire

// ---- design/pin_sync.sv ----
/*
 Two-flop synchroniser for a group of pins that arrive from outside the
 system clock domain. Assumes each bit is an independent level.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= INIT;
         sync_out <= INIT;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule : pin_sync
`default_nettype wire

// ---- design/serial_nand_instruction_decoder.sv ----
/*
 Serial bus instruction front end of one NAND die in continuous read mode.
 Frames instructions between chip-select edges, decodes opcodes, gates them
 on busy, quad inhibit and byte alignment, and serves read data from a FIFO.
 Assumes pins are asynchronous and sampled here; the array side answers
 with array_done and feeds read bytes through rd_data/rd_valid.
*/
// What this block does
// - Chip select falling starts a new frame
// - First eight bits are the opcode
// - Sample on rising clock, MSB first
// - Chip select rising ends the instruction
// - Reads may end after any bit
// - Misaligned write, program, erase are ignored
// - Busy while array operations run
// - While busy only status and ID accepted
// - All basic instructions decoded in x1/x2/x4; the code shifts opcode and parameter bytes in on lane 0 (x1) only
// - Opcode then any address, data, dummy bytes
// - 32h: two address bytes, quad data, buffer reset
// - 3Bh: four dummies, dual output
// - 3Ch: five dummies, dual output
// - 6Bh: four dummies, quad output
// - 6Ch: five dummies, quad output
// - Dual output: odd bits lane one, even lane zero
// - Quad: lane n carries bit n+4 then n
// - Continuous read end: busy and buffer invalid
// - Quad inhibit rejects quad commands
`timescale 1ns/100ps
`default_nettype none
module serial_nand_instruction_decoder #(
   parameter logic [7:0] MAKER_CODE = 8'h5A,   // Arbitrary value
   parameter logic [15:0] PART_CODE = 16'h1234 // Arbitrary value
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic [serial_nand_pkg::LANES-1:0] lane_in,
   output logic [serial_nand_pkg::LANES-1:0] lane_out,
   output logic [serial_nand_pkg::LANES-1:0] lane_oe,
   input wire logic quad_inhibit,
   input wire logic array_done,
   input wire logic [serial_nand_pkg::FIFO_WIDTH-1:0] rd_data,
   input wire logic rd_valid,
   output logic rd_ready,
   output logic [serial_nand_pkg::BYTE_W-1:0] pgm_data,
   output logic pgm_valid,
   output logic buf_restart,
   output logic cmd_exec,
   output logic [serial_nand_pkg::BYTE_W-1:0] cmd_code,
   output logic [serial_nand_pkg::ARG_W-1:0] cmd_arg,
   output logic busy,
   output logic wel,
   output logic buf_invalid
);
   import serial_nand_pkg::*;

   typedef enum {PH_IDLE, PH_OPCODE, PH_PARAM, PH_DUMMY, PH_DIN, PH_DOUT, PH_TAIL,
      PH_IGNORE} ph_t;

   logic [6:0] s_out;
   logic cs_s, sclk_s, qinh_s, cs_d, sclk_d;
   logic [LANES-1:0] lanes_s;
   logic cs_fall, cs_rise, sck_rise, sck_fall;
   ph_t phase;
   cmd_t cmd, dc;
   logic [7:0] opcode, shreg, next_sh, fetch, status;
   logic [2:0] bitpos, next_bitpos, width, byte_cnt;
   logic [ARG_W-1:0] arg;
   logic byte_done, exec_ok, read_end, accept, pop, drive_fall;
   logic [3:0] out_left;
   logic [7:0] out_sh, drv;
   logic [1:0] id_idx;
   logic busy_op, next_busy_op;
   logic [TIMER_W-1:0] rd_timer, next_timer;
   logic [FIFO_WIDTH-1:0] fifo_data;
   logic fifo_valid;

   pin_sync #(.W(7), .INIT(SYNC_INIT)) u_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .async_in({quad_inhibit, lane_in, sclk, cs_n}),
      .sync_out(s_out)
   );

   sync_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .rst_n(rst_n),
      .flush(read_end),
      .in_data(rd_data),
      .in_valid(rd_valid),
      .in_ready(rd_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(pop)
   );

   assign cs_s = s_out[0];
   assign sclk_s = s_out[1];
   assign lanes_s = s_out[5:2];
   assign qinh_s = s_out[6];
   assign cs_fall = cs_d && !cs_s;
   assign cs_rise = !cs_d && cs_s;
   assign sck_rise = !sclk_d && sclk_s && !cs_s;
   assign sck_fall = sclk_d && !sclk_s && !cs_s;

   // Layout of each instruction: parameter, dummy and data phases
   function automatic cmd_t decode(input logic [7:0] op);
      cmd_t c;
      c = '0;
      c.known = 1'b1;
      c.param_lanes = LANE_X1;
      c.dummy_lanes = LANE_X1;
      c.data_lanes = LANE_X1;
      c.quad = op inside {OP_QLOAD, OP_QLOAD_RND, OP_X4_OUT, OP_X4_OUT_EXT, OP_X4_IO,
         OP_X4_IO_EXT};
      c.cont_read = op inside {OP_READ, OP_FREAD, OP_FREAD_EXT, OP_X2_OUT, OP_X2_OUT_EXT,
         OP_X4_OUT, OP_X4_OUT_EXT, OP_X2_IO, OP_X2_IO_EXT, OP_X4_IO, OP_X4_IO_EXT};
      if (c.cont_read) begin
         c.out_kind = 2'(OUT_ARRAY);
      end
      case (op)
         OP_RESET: c.busy_ok = 1'b0;
         OP_WREN, OP_WRDI: c.write_class = 1'b1;
         OP_RDSR_A, OP_RDSR_B: begin
            c.n_param = PARAM_SR;
            c.out_kind = 2'(OUT_STATUS);
            c.busy_ok = 1'b1;
         end
         OP_WRSR_A, OP_WRSR_B: begin
            c.n_param = PARAM_WRSR;
            c.write_class = 1'b1;
         end
         OP_ID: begin
            c.n_dummy = DUMMY_AUX;
            c.out_kind = 2'(OUT_ID);
            c.busy_ok = 1'b1;
         end
         OP_DIE_SEL: c.n_param = PARAM_DIE;
         OP_REMAP: begin
            c.n_param = PARAM_REMAP;
            c.write_class = 1'b1;
            c.starts_op = 1'b1;
         end
         OP_REMAP_LUT, OP_ECC_PAGE: begin
            c.n_dummy = DUMMY_AUX;
            c.out_kind = 2'(OUT_ARRAY);
         end
         OP_ERASE, OP_PGM_EXEC: begin
            c.n_param = PARAM_PAGE;
            c.write_class = 1'b1;
            c.starts_op = 1'b1;
         end
         OP_PAGE_READ: begin
            c.n_param = PARAM_PAGE;
            c.starts_op = 1'b1;
         end
         OP_LOAD, OP_LOAD_RND, OP_QLOAD, OP_QLOAD_RND: begin
            c.n_param = PARAM_COL;
            c.data_in = 1'b1;
            c.write_class = 1'b1;
            c.data_lanes = c.quad ? LANE_X4 : LANE_X1;
         end
         OP_READ: c.n_dummy = DUMMY_READ;
         OP_FREAD: c.n_dummy = DUMMY_FAST;
         OP_FREAD_EXT: c.n_dummy = DUMMY_FAST_EXT;
         OP_X2_OUT, OP_X2_OUT_EXT: begin
            c.n_dummy = (op == OP_X2_OUT) ? DUMMY_FAST : DUMMY_FAST_EXT;
            c.data_lanes = LANE_X2;
         end
         OP_X4_OUT, OP_X4_OUT_EXT: begin
            c.n_dummy = (op == OP_X4_OUT) ? DUMMY_FAST : DUMMY_FAST_EXT;
            c.data_lanes = LANE_X4;
         end
         OP_X2_IO, OP_X2_IO_EXT: begin
            c.n_dummy = (op == OP_X2_IO) ? DUMMY_FAST : DUMMY_FAST_EXT;
            c.dummy_lanes = LANE_X2;
            c.data_lanes = LANE_X2;
         end
         OP_X4_IO, OP_X4_IO_EXT: begin
            c.n_dummy = (op == OP_X4_IO) ? DUMMY_X4_IO : DUMMY_X4_IO_EXT;
            c.dummy_lanes = LANE_X4;
            c.data_lanes = LANE_X4;
         end
         default: c.known = 1'b0;
      endcase
      return c;
   endfunction : decode

   // Phase that follows a finished opcode, parameter or dummy stretch
   function automatic ph_t follow(input cmd_t c, input ph_t from);
      if (from == PH_OPCODE && c.n_param != '0) begin
         return PH_PARAM;
      end
      if (from != PH_DUMMY && c.n_dummy != '0) begin
         return PH_DUMMY;
      end
      if (c.data_in) begin
         return PH_DIN;
      end
      if (c.out_kind != 2'(OUT_NONE)) begin
         return PH_DOUT;
      end
      return PH_TAIL;
   endfunction : follow

   // Input shifting at the lane width of the current phase
   always_comb begin
      width = LANE_X1;
      if (phase == PH_PARAM) begin
         width = cmd.param_lanes;
      end else if (phase == PH_DUMMY) begin
         width = cmd.dummy_lanes;
      end else if (phase == PH_DIN) begin
         width = cmd.data_lanes;
      end
      case (width)
         LANE_X2: next_sh = {shreg[5:0], lanes_s[1], lanes_s[0]};
         LANE_X4: next_sh = {shreg[3:0], lanes_s};
         default: next_sh = {shreg[6:0], lanes_s[0]};
      endcase
      next_bitpos = bitpos + width;
      byte_done = sck_rise && next_bitpos == '0;
      dc = decode(next_sh);
      accept = dc.known && (!busy || dc.busy_ok) && !(dc.quad && qinh_s);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cs_d <= 1'b1;
         sclk_d <= 1'b0;
         shreg <= '0;
         bitpos <= '0;
      end else begin
         cs_d <= cs_s;
         sclk_d <= sclk_s;
         if (cs_fall) begin
            bitpos <= '0;
         end else if (sck_rise) begin
            shreg <= next_sh;
            bitpos <= next_bitpos;
         end
      end
   end

   // Frame sequencer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= PH_IDLE;
         cmd <= '0;
         opcode <= '0;
         byte_cnt <= '0;
         arg <= '0;
      end else if (cs_s) begin
         phase <= PH_IDLE;
      end else if (cs_fall) begin
         phase <= PH_OPCODE;
         byte_cnt <= '0;
         arg <= '0;
      end else if (byte_done) begin
         case (phase)
            PH_OPCODE: begin
               opcode <= next_sh;
               cmd <= dc;
               byte_cnt <= '0;
               phase <= accept ? follow(dc, PH_OPCODE) : PH_IGNORE;
            end
            PH_PARAM, PH_DUMMY: begin
               if (phase == PH_PARAM) begin
                  arg <= {arg[ARG_W-9:0], next_sh};
               end
               byte_cnt <= byte_cnt + 1'b1;
               if (byte_cnt + 1'b1 == (phase == PH_PARAM ? cmd.n_param : cmd.n_dummy)) begin
                  byte_cnt <= '0;
                  phase <= follow(cmd, phase);
               end
            end
            default: byte_cnt <= byte_cnt;
         endcase
      end
   end

   assign exec_ok = cs_rise && (phase inside {PH_DUMMY, PH_DIN, PH_DOUT, PH_TAIL}) &&
      !(cmd.write_class && bitpos != '0);
   assign read_end = cs_rise && cmd.cont_read && (phase inside {PH_DUMMY, PH_DOUT});

   // Program data bytes, buffer restart and executed-instruction report
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pgm_data <= '0;
         pgm_valid <= 1'b0;
         buf_restart <= 1'b0;
         cmd_exec <= 1'b0;
         cmd_code <= '0;
         cmd_arg <= '0;
         buf_invalid <= 1'b0;
      end else begin
         pgm_valid <= byte_done && phase == PH_DIN;
         if (byte_done && phase == PH_DIN) begin
            pgm_data <= next_sh;
         end
         buf_restart <= byte_done && phase == PH_OPCODE && accept &&
            (next_sh == OP_LOAD || next_sh == OP_QLOAD);
         cmd_exec <= exec_ok;
         if (exec_ok) begin
            cmd_code <= opcode;
            cmd_arg <= arg;
         end
         buf_invalid <= read_end;
      end
   end

   // Busy from array operations and from the end of a continuous read
   always_comb begin
      next_busy_op = busy_op;
      if (exec_ok && cmd.starts_op) begin
         next_busy_op = 1'b1;
      end else if (array_done) begin
         next_busy_op = 1'b0;
      end
      next_timer = (rd_timer != '0) ? rd_timer - 1'b1 : rd_timer;
      if (read_end) begin
         next_timer = TIMER_W'(CRD_BUSY_CYC);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         busy_op <= 1'b0;
         rd_timer <= '0;
         busy <= 1'b0;
      end else begin
         busy_op <= next_busy_op;
         rd_timer <= next_timer;
         busy <= next_busy_op || next_timer != '0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wel <= 1'b0;
      end else if (exec_ok) begin
         if (opcode == OP_WREN) begin
            wel <= 1'b1;
         end else if (opcode == OP_WRDI || opcode == OP_RESET || cmd.starts_op) begin
            wel <= 1'b0;
         end
      end
   end

   // Output byte source and lane mapping
   assign drive_fall = sck_fall && phase == PH_DOUT;
   always_comb begin
      status = '0;
      status[ST_BUSY_BIT] = busy;
      status[ST_WEL_BIT] = wel;
      fetch = IDLE_BYTE;
      pop = 1'b0;
      case (cmd.out_kind)
         2'(OUT_ARRAY): begin
            fetch = fifo_valid ? fifo_data : IDLE_BYTE;
            pop = drive_fall && out_left == '0 && fifo_valid;
         end
         2'(OUT_STATUS): fetch = status;
         2'(OUT_ID): fetch = (id_idx == 2'd0) ? MAKER_CODE :
            (id_idx == 2'd1) ? PART_CODE[15:8] : PART_CODE[7:0];
         default: fetch = IDLE_BYTE;
      endcase
      drv = (out_left == '0) ? fetch : out_sh;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lane_out <= '0;
         lane_oe <= '0;
         out_sh <= '0;
         out_left <= '0;
         id_idx <= '0;
      end else if (phase != PH_DOUT) begin
         lane_oe <= '0;
         out_left <= '0;
         id_idx <= '0;
      end else if (drive_fall) begin
         case (cmd.data_lanes)
            LANE_X2: begin
               lane_out <= {2'b00, drv[7], drv[6]};
               lane_oe <= 4'h3;
            end
            LANE_X4: begin
               lane_out <= drv[7:4];
               lane_oe <= 4'hF;
            end
            default: begin
               lane_out <= {2'b00, drv[7], 1'b0};
               lane_oe <= 4'h2;
            end
         endcase
         out_sh <= drv << cmd.data_lanes;
         out_left <= ((out_left == '0) ? 4'd8 : out_left) - {1'b0, cmd.data_lanes};
         if (out_left == '0) begin
            id_idx <= (id_idx == 2'd2) ? 2'd0 : id_idx + 1'b1;
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_frame_start: assert property (cs_fall |=> phase == PH_OPCODE && bitpos == 3'd0)
      else $error("frame did not start on chip select fall");
   a_msb_first: assert property (sck_rise && phase == PH_OPCODE |=>
      shreg == {$past(shreg[6:0]), $past(lanes_s[0])})
      else $error("opcode bit not shifted in msb first");
   a_frame_end: assert property (cs_rise |=> phase == PH_IDLE ##1 lane_oe == 4'h0)
      else $error("frame not closed after chip select rise");
   a_misaligned_drop: assert property (cs_rise && cmd.write_class && bitpos != 3'd0 |=>
      !cmd_exec)
      else $error("misaligned write instruction executed");
   a_busy_ignore: assert property (byte_done && phase == PH_OPCODE && busy && !dc.busy_ok
      |=> phase == PH_IGNORE)
      else $error("instruction accepted while busy");
   a_quad_reject: assert property (byte_done && phase == PH_OPCODE && qinh_s && dc.quad
      |=> phase == PH_IGNORE)
      else $error("quad instruction accepted under inhibit");
   a_crd_busy: assert property (read_end |=> busy [*8])
      else $error("busy not held after continuous read end");
   a_op_busy: assert property (exec_ok && cmd.starts_op |=> busy && !wel)
      else $error("array operation did not raise busy");
   a_x2_lanes: assert property (drive_fall && cmd.data_lanes == LANE_X2 |=>
      lane_oe == 4'h3 && lane_out[1] == $past(drv[7]))
      else $error("dual output lane mapping wrong");
   a_x4_dummy: assert property (byte_done && phase == PH_OPCODE && accept &&
      next_sh == OP_X4_OUT |=> cmd.n_dummy == 3'd4 && cmd.data_lanes == 3'd4)
      else $error("quad output layout wrong");
endmodule : serial_nand_instruction_decoder
`default_nettype wire

// ---- design/serial_nand_pkg.sv ----
/*
 Shared constants for the serial NAND instruction front end: opcodes, byte
 counts of each instruction layout, lane widths, status bit positions and
 the busy time after a continuous read. Assumes a 100 MHz system clock.
*/
package serial_nand_pkg;
   localparam int LANES = 4;
   localparam int BYTE_W = 8;
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int ARG_W = 32;

   localparam logic [7:0] OP_RESET = 8'hFF;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_RDSR_A = 8'h0F;
   localparam logic [7:0] OP_RDSR_B = 8'h05;
   localparam logic [7:0] OP_WRSR_A = 8'h1F;
   localparam logic [7:0] OP_WRSR_B = 8'h01;
   localparam logic [7:0] OP_ID = 8'h9F;
   localparam logic [7:0] OP_DIE_SEL = 8'hC2;
   localparam logic [7:0] OP_REMAP = 8'hA1;
   localparam logic [7:0] OP_REMAP_LUT = 8'hA5;
   localparam logic [7:0] OP_ECC_PAGE = 8'hA9;
   localparam logic [7:0] OP_ERASE = 8'hD8;
   localparam logic [7:0] OP_LOAD = 8'h02;
   localparam logic [7:0] OP_LOAD_RND = 8'h84;
   localparam logic [7:0] OP_QLOAD = 8'h32;
   localparam logic [7:0] OP_QLOAD_RND = 8'h34;
   localparam logic [7:0] OP_PGM_EXEC = 8'h10;
   localparam logic [7:0] OP_PAGE_READ = 8'h13;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FREAD = 8'h0B;
   localparam logic [7:0] OP_FREAD_EXT = 8'h0C;
   localparam logic [7:0] OP_X2_OUT = 8'h3B;
   localparam logic [7:0] OP_X2_OUT_EXT = 8'h3C;
   localparam logic [7:0] OP_X4_OUT = 8'h6B;
   localparam logic [7:0] OP_X4_OUT_EXT = 8'h6C;
   localparam logic [7:0] OP_X2_IO = 8'hBB;
   localparam logic [7:0] OP_X2_IO_EXT = 8'hBC;
   localparam logic [7:0] OP_X4_IO = 8'hEB;
   localparam logic [7:0] OP_X4_IO_EXT = 8'hEC;

   localparam logic [2:0] LANE_X1 = 3'd1;
   localparam logic [2:0] LANE_X2 = 3'd2;
   localparam logic [2:0] LANE_X4 = 3'd4;

   localparam logic [2:0] PARAM_SR = 3'd1;
   localparam logic [2:0] PARAM_WRSR = 3'd2;
   localparam logic [2:0] PARAM_DIE = 3'd1;
   localparam logic [2:0] PARAM_PAGE = 3'd3;
   localparam logic [2:0] PARAM_REMAP = 3'd4;
   localparam logic [2:0] PARAM_COL = 3'd2;
   localparam logic [2:0] DUMMY_AUX = 3'd1;
   localparam logic [2:0] DUMMY_READ = 3'd3;
   localparam logic [2:0] DUMMY_FAST = 3'd4;
   localparam logic [2:0] DUMMY_FAST_EXT = 3'd5;
   localparam logic [2:0] DUMMY_X4_IO = 3'd6;
   localparam logic [2:0] DUMMY_X4_IO_EXT = 3'd7;

   localparam int ST_BUSY_BIT = 0;
   localparam int ST_WEL_BIT = 1;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   localparam logic [6:0] SYNC_INIT = 7'h01;

   localparam int CLK_PERIOD_NS = 10;
   localparam int CRD_BUSY_NS = 5000;
   localparam int CRD_BUSY_CYC = (CRD_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_W = 10;

   typedef enum {OUT_NONE, OUT_ARRAY, OUT_STATUS, OUT_ID} out_kind_t;

   typedef struct packed {
      logic known;
      logic [2:0] n_param;
      logic [2:0] param_lanes;
      logic [2:0] n_dummy;
      logic [2:0] dummy_lanes;
      logic data_in;
      logic [1:0] out_kind;
      logic [2:0] data_lanes;
      logic write_class;
      logic busy_ok;
      logic quad;
      logic cont_read;
      logic starts_op;
   } cmd_t;
endpackage : serial_nand_pkg

// ---- design/sync_fifo.sv ----
/*
 Small synchronous FIFO with registered full and empty flags and a flush.
 Assumes the writer honours in_ready and the reader honours out_valid.
*/
`timescale 1ns/100ps
`default_nettype none
module sync_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr;
   logic [AW-1:0] rptr;
   logic [AW:0] count;
   logic [AW:0] next_count;
   logic push;
   logic pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rptr];

   always_comb begin
      next_count = count;
      if (flush) begin
         next_count = '0;
      end else if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wptr] <= in_data;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         if (flush) begin
            wptr <= '0;
            rptr <= '0;
         end else begin
            if (push) begin
               wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
            end
            if (pop) begin
               rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
            end
         end
         count <= next_count;
         in_ready <= (next_count != (AW + 1)'(DEPTH));
         out_valid <= (next_count != '0);
      end
   end
endmodule : sync_fifo
`default_nettype wire
